//--- verilog/ctmc_pkg.sv
package ctmc_pkg;

  // register indices on the plain register port
  localparam logic [2:0] CTMC_ADDR_CTRL0   = 3'h0;  // pause, clock select, run, period bits
  localparam logic [2:0] CTMC_ADDR_CTRL1   = 3'h1;  // timer_mode_output_control
  localparam logic [2:0] CTMC_ADDR_CNT_LO  = 3'h2;  // counter bits 7..0, read only
  localparam logic [2:0] CTMC_ADDR_CNT_HI  = 3'h3;  // counter bits 9..8, read only
  localparam logic [2:0] CTMC_ADDR_CMPA_LO = 3'h4;  // compare_a_value bits 7..0
  localparam logic [2:0] CTMC_ADDR_CMPA_HI = 3'h5;  // compare_a_value bits 9..8
  localparam logic [2:0] CTMC_ADDR_STATUS  = 3'h6;  // output level, run state

  localparam logic [7:0] CTMC_CTRL0_RST = 8'h00;
  localparam logic [7:0] CTMC_CTRL1_RST = 8'h00;

  // counter and comparator geometry
  localparam int         CTMC_CNT_W   = 10;
  localparam int         CTMC_PER_LSB = 7;
  localparam logic [9:0] CTMC_CNT_MAX = 10'h3ff;

  // clock prescale counts
  localparam logic [5:0] CTMC_DIV_SYS4 = 6'h03;
  localparam logic [5:0] CTMC_DIV_H16  = 6'h0f;
  localparam logic [5:0] CTMC_DIV_H64  = 6'h3f;

  typedef enum logic [1:0] {
    CTMC_MODE_CMP = 2'b00,
    CTMC_MODE_UND = 2'b01,
    CTMC_MODE_PWM = 2'b10,
    CTMC_MODE_TMR = 2'b11
  } ctmc_mode_t;

  typedef enum logic [2:0] {
    CTMC_CK_SYS4 = 3'b000,
    CTMC_CK_SYS  = 3'b001,
    CTMC_CK_H16  = 3'b010,
    CTMC_CK_H64  = 3'b011,
    CTMC_CK_TBC  = 3'b100,
    CTMC_CK_UND  = 3'b101,
    CTMC_CK_EXTR = 3'b110,
    CTMC_CK_EXTF = 3'b111
  } ctmc_clksel_t;

  // first control register layout
  typedef struct packed {
    logic         count_pause;
    ctmc_clksel_t counter_clock_select;
    logic         counter_run_enable;
    logic [2:0]   period_compare_bits;
  } ctmc_ctrl0_t;

  // timer_mode_output_control layout
  typedef struct packed {
    ctmc_mode_t  operating_mode_field;
    logic [1:0]  pin_action_field;
    logic        output_initial_level;
    logic        output_invert;
    logic        period_duty_swap;
    logic        clear_source_select;
  } ctmc_ctrl1_t;

  // plain register port request
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ctmc_req_t;

endpackage : ctmc_pkg

//--- verilog/ctmc_clk_tick.sv
`timescale 1ns/100ps
// counter clock enable generator: one-cycle tick per selected counter clock
module ctmc_clk_tick
  import ctmc_pkg::*;
(
  input  wire logic         sys_clk_i,
  input  wire logic         rst_n_i,
  input  wire ctmc_clksel_t sel_i,
  input  wire logic         tbc_tick_i,
  input  wire logic         ext_i,
  output logic              tick_o
);

  logic [5:0] div_q, div_d;
  logic       ext_q, ext_d;

  // free-running prescaler and edge history of the external input
  always_comb begin
    div_d = div_q + 6'h01;
    ext_d = ext_i;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_q <= 6'h00;
      ext_q <= 1'b0;
    end else begin
      div_q <= div_d;
      ext_q <= ext_d;
    end
  end

  // source select; the undefined code yields no tick
  always_comb begin
    unique case (sel_i)
      CTMC_CK_SYS4: tick_o = ((div_q & CTMC_DIV_SYS4) == CTMC_DIV_SYS4);
      CTMC_CK_SYS:  tick_o = 1'b1;
      CTMC_CK_H16:  tick_o = ((div_q & CTMC_DIV_H16) == CTMC_DIV_H16);
      CTMC_CK_H64:  tick_o = (div_q == CTMC_DIV_H64);
      CTMC_CK_TBC:  tick_o = tbc_tick_i;
      CTMC_CK_UND:  tick_o = 1'b0;
      CTMC_CK_EXTR: tick_o = ext_i & ~ext_q;
      CTMC_CK_EXTF: tick_o = ~ext_i & ext_q;
    endcase
  end

endmodule : ctmc_clk_tick

//--- verilog/ctmc_top.sv
`timescale 1ns/100ps
module ctmc_top
  import ctmc_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       arst_n_i,
  // register port
  input  wire logic [2:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic [7:0]      reg_rdata_o,
  // far side count sources
  input  wire logic       tbc_tick_i,
  input  wire logic       external_count_input_i,
  // timer pins, power state and match pulses
  output logic            timer_output_pin_zero_o,
  output logic            timer_output_pin_one_o,
  output logic            timer_output_oe_o,
  output logic            timer_powered_o,
  output logic            match_a_o,
  output logic            match_p_o
);

  // register map on the plain port
  //   0: pause, counter clock select, run enable, period compare bits
  //   1: timer_mode_output_control
  //   2, 3: counter bits 7..0 and 9..8, read only
  //   4, 5: compare a value bits 7..0 and 9..8
  //   6: status: pwm duty state, compare level, run history, read only
  //   7: unmapped
  // the counter advances on ticks of the selected counter clock; each tick
  // is one system clock wide, so all state sits in the one clock domain

  // reset release synchroniser
  // reset asserts at once and releases two clock edges later, so no flop
  // leaves reset on an edge that the release itself disturbs
  logic rst_s1_q, rst_n;
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  // register state, counter state and pin state
  ctmc_req_t   req;
  ctmc_ctrl0_t ctrl0_q, ctrl0_d;
  ctmc_ctrl1_t ctrl1_q, ctrl1_d;
  logic [9:0]  cmpa_q, cmpa_d;
  logic [7:0]  rdata_q, rdata_d;
  logic [9:0]  cnt_q, cnt_d;
  logic        run_q, run_d;
  logic        out_q, out_d;
  logic        pwm_q, pwm_d;
  logic        hit_p_q, hit_p_d;
  logic        tick;
  logic        eq_a, eq_p, ma, mp, ovf, clr, run_rise;
  logic        lvl, duty_hit;
  logic [2:0]  per_field;
  logic [10:0] per_len;
  logic        cnt_en;
  logic [9:0]  cnt_nx;

  assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};

  // register writes and read data, answered one cycle after the read strobe
  // indices 2, 3 and 6 are read only and index 7 is unmapped: writes there
  // are dropped, and a read of index 7 answers zero
  // read data stand for exactly one cycle and are zero otherwise, so a
  // master that samples late sees zero rather than stale data
  always_comb begin
    ctrl0_d = ctrl0_q;
    ctrl1_d = ctrl1_q;
    cmpa_d  = cmpa_q;
    rdata_d = 8'h00;
    if (req.wr) begin
      unique case (req.addr)
        CTMC_ADDR_CTRL0:   ctrl0_d = ctmc_ctrl0_t'(req.wdata);
        CTMC_ADDR_CTRL1:   ctrl1_d = ctmc_ctrl1_t'(req.wdata);
        CTMC_ADDR_CMPA_LO: cmpa_d[7:0] = req.wdata;
        CTMC_ADDR_CMPA_HI: cmpa_d[9:8] = req.wdata[1:0];
        default:           ;
      endcase
    end
    if (req.rd) begin
      unique case (req.addr)
        CTMC_ADDR_CTRL0:   rdata_d = ctrl0_q;
        CTMC_ADDR_CTRL1:   rdata_d = ctrl1_q;
        CTMC_ADDR_CNT_LO:  rdata_d = cnt_q[7:0];
        CTMC_ADDR_CNT_HI:  rdata_d = {6'h00, cnt_q[9:8]};
        CTMC_ADDR_CMPA_LO: rdata_d = cmpa_q[7:0];
        CTMC_ADDR_CMPA_HI: rdata_d = {6'h00, cmpa_q[9:8]};
        CTMC_ADDR_STATUS:  rdata_d = {5'h00, pwm_q, out_q, run_q};
        default:           rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl0_q <= ctmc_ctrl0_t'(CTMC_CTRL0_RST);
      ctrl1_q <= ctmc_ctrl1_t'(CTMC_CTRL1_RST);
      cmpa_q  <= 10'h000;
      rdata_q <= 8'h00;
    end else begin
      ctrl0_q <= ctrl0_d;
      ctrl1_q <= ctrl1_d;
      cmpa_q  <= cmpa_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_o = rdata_q;

  // counter clock source selection
  // the prescaler runs free, so the first tick after a change of source
  // may come early; the undefined code gives no tick and stops the count
  ctmc_clk_tick u_tick (
    .sys_clk_i  (sys_clk_i),
    .rst_n_i    (rst_n),
    .sel_i      (ctrl0_q.counter_clock_select),
    .tbc_tick_i (tbc_tick_i),
    .ext_i      (external_count_input_i),
    .tick_o     (tick)
  );

  // comparators and clear decision
  // both comparators look at the value the counter takes on this tick, so a
  // clear lands on the match count itself: a period of n counter clocks
  // shows the values 0 to n-1; comparing the present value would stretch
  // every period by one clock
  // the compare a value is written one byte at a time with no buffer, so a
  // running comparator may briefly see a half-written value
  always_comb begin
    per_field = ctrl0_q.period_compare_bits;
    run_rise  = ctrl0_q.counter_run_enable & ~run_q;
    // counting tick: running, not paused, not the restart cycle
    cnt_en    = ctrl0_q.counter_run_enable & ~ctrl0_q.count_pause &
                tick & ~run_rise;
    cnt_nx    = cnt_q + 10'h001;
    eq_a      = (cnt_nx == cmpa_q);
    eq_p      = (cnt_nx[CTMC_CNT_W-1:CTMC_PER_LSB] == per_field) &&
                (per_field != 3'b000);
    // the a comparator matches one count only; the p comparator stays
    // equal for 128 counts, so a latch keeps its pulse to the first one
    ma        = cnt_en & eq_a;
    mp        = cnt_en & eq_p & ~hit_p_q;
    ovf       = (cnt_q == CTMC_CNT_MAX);
    // period length in counter clocks: 000 stands for 1024
    per_len   = (per_field == 3'b000) ? 11'h400 : {1'b0, per_field, 7'h00};
    // pwm: the period register clears the counter and the other sets the duty,
    // or the reverse with the swap bit set; all other modes follow the clear select bit
    if (ctrl1_q.operating_mode_field == CTMC_MODE_PWM) begin
      // the clear select bit plays no part here
      clr = ctrl1_q.period_duty_swap ? ma : (mp | ovf);
    end else if (ctrl1_q.clear_source_select) begin
      clr = ma;
    end else begin
      clr = mp | ovf;
    end
  end

  // counter, period match latch and run edge history
  // a run enable rising edge wins over a counting tick in the same cycle, so
  // a restart always begins from zero; a falling edge simply stops the
  // ticks and the count stays where it was
  always_comb begin
    cnt_d   = cnt_q;
    hit_p_d = hit_p_q;
    run_d   = ctrl0_q.counter_run_enable;
    if (run_rise) begin
      cnt_d   = 10'h000;
      hit_p_d = 1'b0;
    end else if (cnt_en) begin
      hit_p_d = eq_p;
      cnt_d   = clr ? 10'h000 : cnt_nx;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q   <= 10'h000;
      hit_p_q <= 1'b0;
      run_q   <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      hit_p_q <= hit_p_d;
      run_q   <= run_d;
    end
  end

  // compare-mode pin level and PWM duty state
  // the compare level changes only on a restart or on a counting tick that matches, so a
  // toggle happens once per match even with a slow counter clock
  // the duty state is kept in every mode, so the pwm waveform is ready the
  // moment the pin action field selects it
  always_comb begin
    out_d = out_q;
    pwm_d = pwm_q;
    duty_hit = ctrl1_q.period_duty_swap
             ? ({1'b0, cnt_q} >= per_len)
             : (cnt_q >= cmpa_q);
    if (run_rise) begin
      if (ctrl1_q.operating_mode_field == CTMC_MODE_CMP) begin
        out_d = ctrl1_q.output_initial_level;
      end
    end else if (ma && ctrl1_q.operating_mode_field == CTMC_MODE_CMP) begin
      // setting a level equal to the present one leaves the pin unchanged
      unique case (ctrl1_q.pin_action_field)
        2'b00: out_d = out_q;
        2'b01: out_d = 1'b0;
        2'b10: out_d = 1'b1;
        2'b11: out_d = ~out_q;
      endcase
    end
    // duty phase is active until the duty compare value is reached
    pwm_d = ctrl0_q.counter_run_enable & ~duty_hit;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      out_q <= 1'b0;
      pwm_q <= 1'b0;
    end else begin
      out_q <= out_d;
      pwm_q <= pwm_d;
    end
  end

  // pin level by mode, then polarity inversion
  // forced pwm levels follow the active polarity: active is the initial
  // level bit, inactive its inverse; the undefined codes give a low level
  always_comb begin
    lvl = 1'b0;
    unique case (ctrl1_q.operating_mode_field)
      CTMC_MODE_CMP: lvl = out_q;
      CTMC_MODE_PWM: begin
        unique case (ctrl1_q.pin_action_field)
          2'b00: lvl = ~ctrl1_q.output_initial_level;
          2'b01: lvl = ctrl1_q.output_initial_level;
          2'b10: lvl = pwm_q ? ctrl1_q.output_initial_level
                             : ~ctrl1_q.output_initial_level;
          2'b11: lvl = 1'b0;
        endcase
      end
      CTMC_MODE_TMR: lvl = 1'b0;
      CTMC_MODE_UND: lvl = 1'b0;
    endcase
  end

  // both pins carry the same signal, the second one inverted
  assign timer_output_pin_zero_o = lvl ^ ctrl1_q.output_invert;
  assign timer_output_pin_one_o  = ~timer_output_pin_zero_o;
  // no drive in timer/counter or undefined mode
  assign timer_output_oe_o = ~ctrl1_q.operating_mode_field[0];
  assign timer_powered_o   = ctrl0_q.counter_run_enable;
  // match pulses are already one counting tick wide
  assign match_a_o         = ma;
  assign match_p_o         = mp;

endmodule : ctmc_top

//--- test/ctmc_top_asserts.sv
`timescale 1ns/100ps
// watches the timer ports against a shadow of the control register writes
module ctmc_top_asserts
  import ctmc_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       arst_n_i,
  input  wire logic [2:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_rdata_o,
  input  wire logic       timer_output_pin_zero_o,
  input  wire logic       timer_output_oe_o,
  input  wire logic       timer_powered_o,
  input  wire logic       match_a_o,
  input  wire logic       match_p_o
);
  ctmc_ctrl0_t c0_q;
  ctmc_ctrl1_t c1_q;
  logic [1:0]  quiet_q;
  default clocking @(posedge sys_clk_i);
  endclocking
  default disable iff (!arst_n_i);
  // shadow registers and settled-cycle count since the last write
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      c0_q    <= '0;
      c1_q    <= '0;
      quiet_q <= 2'h0;
    end else begin
      if (reg_wr_i && reg_addr_i == CTMC_ADDR_CTRL0) c0_q <= ctmc_ctrl0_t'(reg_wdata_i);
      if (reg_wr_i && reg_addr_i == CTMC_ADDR_CTRL1) c1_q <= ctmc_ctrl1_t'(reg_wdata_i);
      quiet_q <= reg_wr_i ? 2'h0 : quiet_q + {1'b0, quiet_q != 2'h3};
    end
  end
  a_oe_by_mode: assert property (
    timer_output_oe_o == !c1_q.operating_mode_field[0])
    else $error("output enable does not follow mode");
  a_power_follows_run: assert property (
    timer_powered_o == c0_q.counter_run_enable)
    else $error("power state does not follow run bit");
  a_match_a_once: assert property (match_a_o |=> !match_a_o)
    else $error("compare a pulse too long");
  a_match_p_once: assert property (match_p_o |=> !match_p_o)
    else $error("period pulse too long");
  a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data outside its cycle");
  a_no_period_zero: assert property (
    quiet_q == 2'h3 && c0_q.period_compare_bits == 3'h0 |-> !match_p_o)
    else $error("period match with zero period");
  a_cmp_hold: assert property (
    quiet_q == 2'h3 && c1_q.operating_mode_field == CTMC_MODE_CMP
    && c1_q.pin_action_field == 2'h0 |-> $stable(timer_output_pin_zero_o))
    else $error("pin moved with no action");
  a_pwm_forced: assert property (
    quiet_q == 2'h3 && c1_q.operating_mode_field == CTMC_MODE_PWM && !c1_q.pin_action_field[1]
    |-> timer_output_pin_zero_o == ((c1_q.pin_action_field[0] ? c1_q.output_initial_level
    : !c1_q.output_initial_level) ^ c1_q.output_invert))
    else $error("forced pwm level wrong");
endmodule : ctmc_top_asserts

bind ctmc_top ctmc_top_asserts u_chk (
  .sys_clk_i, .arst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
  .timer_output_pin_zero_o, .timer_output_oe_o, .timer_powered_o, .match_a_o, .match_p_o);

//--- test/ctmc_far_side.sv
`timescale 1ns/100ps
// far side sources: time base tick and external count pin
module ctmc_far_side #(
  parameter int TBC_DIV  = 8,
  parameter int EXT_HALF = 5
) (
  input  wire logic sys_clk_i,
  output logic      tbc_tick_o,
  output logic      ext_o
);
  int   tcnt_q = 0;
  int   ecnt_q = 0;
  logic tick_q = 1'b0;
  logic pin_q  = 1'b0;
  assign tbc_tick_o = tick_q;
  assign ext_o      = pin_q;
  // one tick in every TBC_DIV cycles, pin toggles every EXT_HALF cycles
  always @(posedge sys_clk_i) begin
    tcnt_q <= (tcnt_q == TBC_DIV - 1) ? 0 : tcnt_q + 1;
    tick_q <= (tcnt_q == TBC_DIV - 1);
    ecnt_q <= (ecnt_q == EXT_HALF - 1) ? 0 : ecnt_q + 1;
    if (ecnt_q == EXT_HALF - 1) pin_q <= !pin_q;
  end
endmodule : ctmc_far_side

//--- test/compact_timer_control_bench.sv
`timescale 1ns/100ps
module compact_timer_control_bench;
  import ctmc_pkg::*;
  logic       sys_clk = 1'b0;
  logic       arst_n = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [7:0] rdata, d1, d2, v;
  logic       tbc, ext, pin0, pin1, oe, pwr, ma, mp, e;
  int         n_mismatch = 0;
  int         n_compared = 0;
  int         seed = 43865;
  int         n, h;
  logic [2:0] ck_s [6] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h6, 3'h7};
  int         ck_d [6] = '{4, 16, 64, 8, 10, 10};
  logic [7:0] pw_c [5] = '{8'ha9, 8'hae, 8'h88, 8'h98, 8'ha0};
  int         pw_a [5] = '{32, 384, 32, 32, 32};
  int         pw_w [5] = '{128, 384, 128, 128, 128};
  int         pw_e [5] = '{32, 256, 0, 128, 96};
  ctmc_top dut (.sys_clk_i(sys_clk), .arst_n_i(arst_n), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .tbc_tick_i(tbc),
    .external_count_input_i(ext), .timer_output_pin_zero_o(pin0),
    .timer_output_pin_one_o(pin1), .timer_output_oe_o(oe), .timer_powered_o(pwr),
    .match_a_o(ma), .match_p_o(mp));
  ctmc_far_side far (.sys_clk_i(sys_clk), .tbc_tick_o(tbc), .ext_o(ext));
  initial forever #50 sys_clk = ~sys_clk;
  task automatic chk(input string nm, input logic [15:0] x, input logic [15:0] g);
    n_compared++;
    if (g !== x) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, x, g);
    end
  endtask : chk
  task automatic wrr(input logic [2:0] a, input logic [7:0] val);
    @(posedge sys_clk);
    addr  <= a;
    wdata <= val;
    wr    <= 1'b1;
    @(posedge sys_clk);
    wr    <= 1'b0;
  endtask : wrr
  task automatic rdr(input logic [2:0] a, output logic [7:0] q);
    @(posedge sys_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge sys_clk);
    rd   <= 1'b0;
    @(negedge sys_clk);
    q = rdata;
  endtask : rdr
  task automatic wcmp(input logic [9:0] val);
    wrr(CTMC_ADDR_CMPA_LO, val[7:0]);
    wrr(CTMC_ADDR_CMPA_HI, {6'h00, val[9:8]});
  endtask : wcmp
  // cycles until the next pulse of the chosen comparator
  task automatic wpulse(input bit p, output int c);
    c = 0;
    do begin
      @(negedge sys_clk);
      c++;
    end while (((p ? mp : ma) !== 1'b1) && c < 20000);
  endtask : wpulse
  task automatic chkpin(input logic x);
    chk("pin zero", x, pin0);
    chk("pin one", !x, pin1);
  endtask : chkpin
  task automatic end_of_test;
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (90000) @(posedge sys_clk);
    n_mismatch++;
    end_of_test();
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    wrr(3'h7, 8'hff);
    for (int a = 0; a < 8; a++) begin
      rdr(a[2:0], d1);
      chk("reset read", 8'h00, d1);
    end
    for (int m = 0; m < 4; m++) begin
      v = {m[1:0], 6'($random(seed))};
      wrr(CTMC_ADDR_CTRL1, v);
      rdr(CTMC_ADDR_CTRL1, d1);
      chk("mode control", v, d1);
      chk("output enable", !m[0], oe);
    end
    wrr(CTMC_ADDR_CTRL1, 8'h00);
    wcmp(10'h155);
    // run, stop, restart with the dead clock code, pause
    wrr(CTMC_ADDR_CTRL0, 8'h18);
    repeat (50) @(posedge sys_clk);
    wrr(CTMC_ADDR_CTRL0, 8'h10);
    rdr(CTMC_ADDR_CNT_LO, d1);
    repeat (20) @(posedge sys_clk);
    rdr(CTMC_ADDR_CNT_LO, d2);
    chk("held count", d1, d2);
    wrr(CTMC_ADDR_CTRL0, 8'h58);
    repeat (20) @(posedge sys_clk);
    rdr(CTMC_ADDR_CNT_LO, d1);
    chk("cleared count", 8'h00, d1);
    wrr(CTMC_ADDR_CTRL0, 8'h18);
    repeat (10) @(posedge sys_clk);
    wrr(CTMC_ADDR_CTRL0, 8'h98);
    rdr(CTMC_ADDR_CNT_LO, d1);
    repeat (20) @(posedge sys_clk);
    rdr(CTMC_ADDR_CNT_LO, d2);
    chk("paused count", d1, d2);
    chk("paused power", 1'b1, pwr);
    for (int p = 0; p < 8; p++) begin
      wrr(CTMC_ADDR_CTRL0, {5'b00011, p[2:0]});
      wpulse(p != 0, n);
      wpulse(p != 0, n);
      chk("match interval", (p == 0) ? 1024 : 128 * p, n);
    end
    for (int i = 0; i < 6; i++) begin
      wrr(CTMC_ADDR_CTRL0, {1'b0, ck_s[i], 4'h9});
      wpulse(1'b1, n);
      wpulse(1'b1, n);
      chk("clock interval", 128 * ck_d[i], n);
    end
    wrr(CTMC_ADDR_CTRL1, 8'h01);
    wrr(CTMC_ADDR_CTRL0, 8'h19);
    wpulse(1'b0, n);
    wpulse(1'b0, n);
    chk("a clear interval", 341, n);
    // pin actions in compare mode with random level and invert
    for (int k = 0; k < 4; k++) begin
      v = 8'($random(seed));
      wrr(CTMC_ADDR_CTRL0, 8'h10);
      wrr(CTMC_ADDR_CTRL1, {2'b00, k[1:0], v[0], v[1], 2'b01});
      wrr(CTMC_ADDR_CTRL0, 8'h18);
      repeat (4) @(negedge sys_clk);
      chkpin(v[0] ^ v[1]);
      wpulse(1'b0, n);
      repeat (2) @(negedge sys_clk);
      e = (k == 0) ? v[0] : (k == 3) ? !v[0] : k[1];
      chkpin(e ^ v[1]);
    end
    // pwm duty counted over one full period
    for (int r = 0; r < 5; r++) begin
      wrr(CTMC_ADDR_CTRL0, 8'h10);
      wrr(CTMC_ADDR_CTRL1, pw_c[r]);
      wcmp(10'(pw_a[r]));
      wrr(CTMC_ADDR_CTRL0, 8'h19);
      repeat (2 * pw_w[r]) @(negedge sys_clk);
      h = 0;
      repeat (pw_w[r]) begin
        @(negedge sys_clk);
        h += (pin0 === 1'b1);
      end
      chk("pwm high count", pw_e[r], h);
    end
    end_of_test();
  end
endmodule : compact_timer_control_bench
